/* rtl/tbfl_defines.svh */
// constants for the block frame link: field positions, codes and limits
`ifndef TBFL_DEFINES_SVH
`define TBFL_DEFINES_SVH
`define TBFL_NAD_VAL        8'h00
`define TBFL_INF_MAX        8'hfe
`define TBFL_PCB_I_SEQ      6
`define TBFL_PCB_I_MORE     5
`define TBFL_PCB_R_SEQ      4
`define TBFL_R_BASE         8'h80
`define TBFL_R_ERR          8'h01
`define TBFL_S_BASE         8'hc0
`define TBFL_S_RESP         8'h20
`define TBFL_S_RESYNCH      8'h00
`define TBFL_S_IFS          8'h01
`define TBFL_S_ABORT        8'h02
`define TBFL_S_WTX          8'h03
`define TBFL_S_VPP          8'h04
`define TBFL_RECEIVE_SIZE_LIMIT_RST 8'h20
`endif

/* rtl/tbfl_pkg.sv */
// types shared by both ends of the block frame link
package tbfl_pkg;
  typedef enum logic [1:0] {
    TBFL_BLK_I = 2'h0,
    TBFL_BLK_R = 2'h2,
    TBFL_BLK_S = 2'h3
  } tbfl_blk_t;
endpackage : tbfl_pkg

/* rtl/tbfl_link_if.sv */
// byte link between terminal and card: clock, byte strobe, data
`timescale 1ns/10ps
interface tbfl_link_if;
  logic       link_clk;   // made by the terminal end
  logic       t2c_vld;    // terminal byte strobe
  logic [7:0] t2c_dat;
  logic       t2c_eob;    // last byte of a block
  logic       c2t_vld;    // card byte strobe
  logic [7:0] c2t_dat;
  logic       c2t_eob;
  modport card (input link_clk, t2c_vld, t2c_dat, t2c_eob,
                output c2t_vld, c2t_dat, c2t_eob);
  modport term (output link_clk, t2c_vld, t2c_dat, t2c_eob,
                input c2t_vld, c2t_dat, c2t_eob);
endinterface : tbfl_link_if

/* rtl/tbfl_card.sv */
// card end: receives terminal blocks, checks them, sends answers
// How it works
// [RQ1] length byte equals information byte count
// [RQ2] information field holds 0 to 254 bytes
// [RQ3] information blocks always carry data
// [RQ4] receive-ready blocks carry no data
// [RQ5] size and wait supervisory blocks carry one byte; the card answers a wait request with an empty wait response
// [RQ6] abort, resync, voltage error carry no data
// [RQ7] every block ends with xor check byte
// [RQ8] bad check byte answered with error receive-ready
// [RQ9] error answer names expected sequence, no advance
// [RQ10] size request echoed in size response
// [RQ11] accepted size limit held until next request
// [RQ12] last information block answered by information block
// [RQ13] chained block answered by receive-ready, other sequence
// [RQ14] abort request answered by empty abort response
// [RQ15] resync request answered by empty resync response
// [RQ16] node address byte is zero
// [RQ17] control byte alone gives block type
// [RQ18] order: address, control, length, data, check
// [RQ19] length mismatch treated as check error
`timescale 1ns/10ps
`include "tbfl_defines.svh"
module tbfl_card (
  // link side, on the link clock
  tbfl_link_if.card           LINK,
  // user side: received information bytes
  output logic                RX_VLD_O,
  output logic [7:0]          RX_DAT_O,
  // user side: response byte for I answers, held stable
  input  wire logic [7:0]     RSP_DAT_I,
  input  wire logic [7:0]     RSP_LEN_I,
  // state
  output logic [7:0]          TERMINAL_RECEIVE_SIZE_LIMIT_O,
  // reset
  input  wire logic           NRST_I
);
  import tbfl_pkg::*;

  // receive position within the block
  logic [1:0] ph_reg;          // 0 nad,1 pcb,2 len,3 body
  logic [7:0] pcb_reg, len_reg, cnt_reg, lrc_reg, inf0_reg;
  logic       bad_reg;
  logic       nr_reg;          // next expected terminal sequence
  logic       ns_reg;          // own send sequence
  logic [7:0] terminal_receive_size_limit_reg;
  // transmit image
  logic [7:0] tx_pcb_reg, tx_len_reg, tx_inf_reg, tx_lrc_reg;
  logic [2:0] tx_ph_reg;
  logic       tx_go_reg;
  logic [7:0] tx_cnt_reg;
  logic [7:0] lrc_next;
  logic       done;

  // block type decoded from control byte only
  function automatic tbfl_blk_t blk_type(input logic [7:0] p);
    if (!p[7])     return TBFL_BLK_I; // RQ17
    else if (!p[6]) return TBFL_BLK_R;
    else            return TBFL_BLK_S;
  endfunction : blk_type

  assign lrc_next = lrc_reg ^ LINK.t2c_dat; // RQ7
  assign done = LINK.t2c_vld && LINK.t2c_eob;

  // receive framing and checks
  always_ff @(posedge LINK.link_clk or negedge NRST_I) begin
    if (!NRST_I) begin
      ph_reg   <= 2'h0;
      pcb_reg  <= 8'h00;
      len_reg  <= 8'h00;
      cnt_reg  <= 8'h00;
      lrc_reg  <= 8'h00;
      inf0_reg <= 8'h00;
      bad_reg  <= 1'b0;
    end else if (LINK.t2c_vld) begin
      lrc_reg <= done ? 8'h00 : lrc_next;
      case (ph_reg)
        2'h0: begin
          bad_reg <= (LINK.t2c_dat != `TBFL_NAD_VAL); // RQ16
          ph_reg  <= 2'h1;
        end
        2'h1: begin
          pcb_reg <= LINK.t2c_dat;
          ph_reg  <= 2'h2;
        end
        2'h2: begin
          len_reg <= LINK.t2c_dat;
          cnt_reg <= 8'h00;
          if (LINK.t2c_dat > `TBFL_INF_MAX) bad_reg <= 1'b1; // RQ2
          ph_reg  <= 2'h3;
        end
        default: begin
          if (!LINK.t2c_eob) begin
            if (cnt_reg == 8'h00) inf0_reg <= LINK.t2c_dat;
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
      endcase
      if (done) ph_reg <= 2'h0; // RQ18
    end
  end

  // information bytes to user, from flops
  always_ff @(posedge LINK.link_clk or negedge NRST_I) begin
    if (!NRST_I) begin
      RX_VLD_O <= 1'b0;
      RX_DAT_O <= 8'h00;
    end else begin
      RX_VLD_O <= LINK.t2c_vld && !LINK.t2c_eob && ph_reg == 2'h3
                  && !pcb_reg[7];
      RX_DAT_O <= LINK.t2c_dat;
    end
  end

  // block verdict: good when check, address and length all agree
  logic good;
  always_comb begin
    good = !bad_reg && (lrc_next == 8'h00) && ph_reg == 2'h3
           && (cnt_reg == len_reg); // RQ19 RQ1
    case (blk_type(pcb_reg))
      TBFL_BLK_I: if (len_reg == 8'h00) good = 1'b0; // RQ3
      TBFL_BLK_R: if (len_reg != 8'h00) good = 1'b0; // RQ4
      default: begin
        if (pcb_reg[1:0] == 2'h1 || pcb_reg[1:0] == 2'h3) begin
          if (len_reg != 8'h01) good = 1'b0; // RQ5
        end else if (len_reg != 8'h00) good = 1'b0; // RQ6
      end
    endcase
  end

  // answer length held to the accepted size limit; longer answers are
  // cut, since chaining of card responses is not built here
  logic [7:0] rsp_len_lim;
  always_comb begin
    rsp_len_lim = RSP_LEN_I;
    if (rsp_len_lim > terminal_receive_size_limit_reg)
      rsp_len_lim = terminal_receive_size_limit_reg; // RQ11
    if (rsp_len_lim > `TBFL_INF_MAX) rsp_len_lim = `TBFL_INF_MAX; // RQ2
    if (rsp_len_lim == 8'h00) rsp_len_lim = 8'h01; // RQ3
  end

  // answer selection and sequence state
  always_ff @(posedge LINK.link_clk or negedge NRST_I) begin
    if (!NRST_I) begin
      nr_reg     <= 1'b0;
      ns_reg     <= 1'b0;
      terminal_receive_size_limit_reg <= `TBFL_RECEIVE_SIZE_LIMIT_RST;
      tx_pcb_reg <= 8'h00;
      tx_len_reg <= 8'h00;
      tx_inf_reg <= 8'h00;
      tx_go_reg  <= 1'b0;
    end else begin
      tx_go_reg <= done;
      if (done) begin
        tx_len_reg <= 8'h00;
        if (!good) begin
          // erroneous block ignored, sequence stays
          tx_pcb_reg <= `TBFL_R_BASE | `TBFL_R_ERR |
                        {3'h0, nr_reg, 4'h0}; // RQ8 RQ9
        end else begin
          case (blk_type(pcb_reg))
            TBFL_BLK_I: begin
              nr_reg <= ~pcb_reg[`TBFL_PCB_I_SEQ];
              if (pcb_reg[`TBFL_PCB_I_MORE])
                tx_pcb_reg <= `TBFL_R_BASE |
                  {3'h0, ~pcb_reg[`TBFL_PCB_I_SEQ], 4'h0}; // RQ13
              else begin
                tx_pcb_reg <= {1'b0, ns_reg, 6'h00}; // RQ12
                tx_len_reg <= rsp_len_lim; // RQ11
                tx_inf_reg <= RSP_DAT_I;
                ns_reg     <= ~ns_reg;
              end
            end
            TBFL_BLK_R: tx_pcb_reg <= `TBFL_R_BASE |
                                      {3'h0, nr_reg, 4'h0};
            default: begin
              tx_pcb_reg <= pcb_reg | `TBFL_S_RESP;
              if ({3'h0, pcb_reg[4:0]} == `TBFL_S_IFS) begin
                terminal_receive_size_limit_reg <= inf0_reg; // RQ11
                tx_len_reg <= 8'h01;     // RQ10
                tx_inf_reg <= inf0_reg;
              end else if ({3'h0, pcb_reg[4:0]} == `TBFL_S_RESYNCH) begin
                nr_reg <= 1'b0;          // RQ15
                ns_reg <= 1'b0;
              end
              // abort response leaves length at zero: RQ14
            end
          endcase
        end
      end
    end
  end
  assign TERMINAL_RECEIVE_SIZE_LIMIT_O = terminal_receive_size_limit_reg;

  // transmit serialiser with running check byte
  always_ff @(posedge LINK.link_clk or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_ph_reg    <= 3'h0;
      tx_cnt_reg   <= 8'h00;
      tx_lrc_reg   <= 8'h00;
      LINK.c2t_vld <= 1'b0;
      LINK.c2t_dat <= 8'h00;
      LINK.c2t_eob <= 1'b0;
    end else begin
      LINK.c2t_vld <= 1'b0;
      LINK.c2t_eob <= 1'b0;
      case (tx_ph_reg)
        3'h0: if (tx_go_reg) begin
          LINK.c2t_vld <= 1'b1;
          LINK.c2t_dat <= `TBFL_NAD_VAL; // RQ16
          tx_lrc_reg   <= `TBFL_NAD_VAL;
          tx_ph_reg    <= 3'h1;
        end
        3'h1: begin
          LINK.c2t_vld <= 1'b1;
          LINK.c2t_dat <= tx_pcb_reg;
          tx_lrc_reg   <= tx_lrc_reg ^ tx_pcb_reg;
          tx_ph_reg    <= 3'h2;
        end
        3'h2: begin
          LINK.c2t_vld <= 1'b1;
          LINK.c2t_dat <= tx_len_reg; // RQ1
          tx_lrc_reg   <= tx_lrc_reg ^ tx_len_reg;
          tx_cnt_reg   <= 8'h00;
          tx_ph_reg    <= (tx_len_reg == 8'h00) ? 3'h4 : 3'h3;
        end
        3'h3: begin
          LINK.c2t_vld <= 1'b1;
          LINK.c2t_dat <= tx_inf_reg;
          tx_lrc_reg   <= tx_lrc_reg ^ tx_inf_reg;
          tx_cnt_reg   <= tx_cnt_reg + 8'h01;
          if (tx_cnt_reg + 8'h01 == tx_len_reg) tx_ph_reg <= 3'h4;
        end
        default: begin
          LINK.c2t_vld <= 1'b1;
          LINK.c2t_eob <= 1'b1;
          LINK.c2t_dat <= tx_lrc_reg; // RQ7 RQ18
          tx_ph_reg    <= 3'h0;
        end
      endcase
    end
  end
endmodule : tbfl_card

/* rtl/tbfl_term.sv */
// terminal end: makes the link clock, sends user blocks, checks answers
`timescale 1ns/10ps
`include "tbfl_defines.svh"
module tbfl_term (
  // clock and reset
  input  wire logic           REF_CLK_I,
  input  wire logic           NRST_I,
  // link side
  tbfl_link_if.term           LINK,
  // user send request: one block, fixed body byte repeated
  input  wire logic           SEND_I,
  input  wire logic [7:0]     PCB_I,
  input  wire logic [7:0]     LEN_I,
  input  wire logic [7:0]     INF_I,
  input  wire logic [1:0]     FAULT_I,   // bit0 bad check, bit1 short body
  output logic                BUSY_O,
  // answer report
  output logic                ANS_VLD_O,
  output logic [7:0]          ANS_PCB_O,
  output logic                ANS_OK_O
);
  import tbfl_pkg::*;

  // link clock divider: link clock is REF/4
  logic [1:0] div_reg;
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) div_reg <= 2'h0;
    else         div_reg <= div_reg + 2'h1;
  end
  assign LINK.link_clk = div_reg[1];
  logic lk_rise;
  assign lk_rise = (div_reg == 2'h1); // link edge on next ref edge

  logic lk_fall;
  assign lk_fall = (div_reg == 2'h3); // link falls on next ref edge
  logic ack_vld, ack_eob;
  // card strobes change just after the link rises, so at lk_rise the
  // previous card byte is still settled and is sampled once
  assign ack_vld = lk_rise && LINK.c2t_vld;
  assign ack_eob = LINK.c2t_eob;

  // transmit serialiser, one byte per link cycle; bytes launch as the
  // link falls so the card edge never races the data
  logic [2:0] ph_reg;
  logic [7:0] cnt_reg, lrc_reg, pcb_reg, len_reg, inf_reg;
  logic [1:0] fault_reg;
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ph_reg       <= 3'h0;
      fault_reg    <= 2'h0;
      cnt_reg      <= 8'h00;
      lrc_reg      <= 8'h00;
      pcb_reg      <= 8'h00;
      len_reg      <= 8'h00;
      inf_reg      <= 8'h00;
      LINK.t2c_vld <= 1'b0;
      LINK.t2c_dat <= 8'h00;
      LINK.t2c_eob <= 1'b0;
    end else if (ph_reg == 3'h0) begin
      if (SEND_I) begin
        pcb_reg <= PCB_I;
        len_reg <= (LEN_I > `TBFL_INF_MAX) ? `TBFL_INF_MAX : LEN_I;
        inf_reg <= INF_I;
        fault_reg <= FAULT_I;
        ph_reg  <= 3'h1;
      end
    end else if (lk_fall) begin
      LINK.t2c_vld <= 1'b1;
      LINK.t2c_eob <= 1'b0;
      case (ph_reg)
        3'h1: begin
          LINK.t2c_dat <= `TBFL_NAD_VAL;
          lrc_reg      <= `TBFL_NAD_VAL;
          ph_reg       <= 3'h2;
        end
        3'h2: begin
          LINK.t2c_dat <= pcb_reg;
          lrc_reg      <= lrc_reg ^ pcb_reg;
          ph_reg       <= 3'h3;
        end
        3'h3: begin
          LINK.t2c_dat <= len_reg;
          lrc_reg      <= lrc_reg ^ len_reg;
          cnt_reg      <= {7'h00, fault_reg[1]}; // short body drops one unless length is 0 or 1
          ph_reg       <= (len_reg == 8'h00) ? 3'h5 : 3'h4;
        end
        3'h4: begin
          LINK.t2c_dat <= inf_reg;
          lrc_reg      <= lrc_reg ^ inf_reg;
          cnt_reg      <= cnt_reg + 8'h01;
          if (cnt_reg + 8'h01 >= len_reg) ph_reg <= 3'h5;
        end
        3'h5: begin
          LINK.t2c_dat <= lrc_reg ^ {7'h00, fault_reg[0]}; // RQ7
          LINK.t2c_eob <= 1'b1;
          ph_reg       <= 3'h6;
        end
        default: begin
          LINK.t2c_vld <= 1'b0;
          LINK.t2c_eob <= 1'b0;
          ph_reg       <= 3'h0;
        end
      endcase
    end
  end
  assign BUSY_O = (ph_reg != 3'h0);

  // answer check: running xor must be zero at the check byte
  logic [7:0] rlrc_reg;
  logic [1:0] rph_reg;
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rlrc_reg  <= 8'h00;
      rph_reg   <= 2'h0;
      ANS_VLD_O <= 1'b0;
      ANS_PCB_O <= 8'h00;
      ANS_OK_O  <= 1'b0;
    end else begin
      ANS_VLD_O <= 1'b0;
      if (ack_vld) begin
        rlrc_reg <= ack_eob ? 8'h00 : rlrc_reg ^ LINK.c2t_dat;
        if (rph_reg == 2'h1) ANS_PCB_O <= LINK.c2t_dat;
        if (rph_reg != 2'h3) rph_reg <= rph_reg + 2'h1;
        if (ack_eob) begin
          rph_reg   <= 2'h0;
          ANS_VLD_O <= 1'b1;
          ANS_OK_O  <= (rlrc_reg == LINK.c2t_dat);
        end
      end
    end
  end
endmodule : tbfl_term

/* tb/tbfl_link_assertions.sv */
// checker for the card side of the block frame link
`timescale 1ns/10ps
module tbfl_link_assertions (
  // link signals
  input wire logic       link_clk,
  input wire logic       t2c_vld,
  input wire logic       t2c_eob,
  input wire logic       c2t_vld,
  input wire logic [7:0] c2t_dat,
  input wire logic       c2t_eob,
  // reset
  input wire logic       NRST_I
);
  logic [8:0] idx_reg;
  logic [7:0] lrc_reg;
  logic [7:0] pcb_reg;
  logic [7:0] len_reg;
  logic       len_byte;
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!NRST_I);
  // byte position and running xor of the card block, cleared at its end
  always_ff @(posedge link_clk or negedge NRST_I) begin
    if (!NRST_I) begin
      idx_reg <= 9'h000;
      lrc_reg <= 8'h00;
    end else if (c2t_vld) begin
      idx_reg <= c2t_eob ? 9'h000 : idx_reg + 9'h001;
      lrc_reg <= c2t_eob ? 8'h00 : lrc_reg ^ c2t_dat;
    end
  end
  // control and length bytes kept for the type checks
  always_ff @(posedge link_clk or negedge NRST_I) begin
    if (!NRST_I) begin
      pcb_reg <= 8'h00;
      len_reg <= 8'h00;
    end else if (c2t_vld && idx_reg == 9'h001) begin
      pcb_reg <= c2t_dat;
    end else if (len_byte) begin
      len_reg <= c2t_dat;
    end
  end
  assign len_byte = c2t_vld && idx_reg == 9'h002;
  sequence blk_end_s;
    t2c_vld && t2c_eob;
  endsequence
  sequence ans_start_s;
    c2t_vld && c2t_dat == 8'h00 && idx_reg == 9'h000;
  endsequence
  ans_timing_a: assert property (blk_end_s |-> ##2 ans_start_s)
    else $error("card answer late or bad address");
  half_duplex_a: assert property (c2t_vld |-> !t2c_vld)
    else $error("both ends sending");
  eob_byte_a: assert property (c2t_eob |-> c2t_vld)
    else $error("end flag without byte");
  check_byte_a: assert property (c2t_vld && c2t_eob |->
    c2t_dat == lrc_reg)
    else $error("card check byte wrong");
  len_count_a: assert property (c2t_vld && c2t_eob |->
    idx_reg == {1'b0, len_reg} + 9'h003)
    else $error("card length byte disagrees with count");
  r_empty_a: assert property (len_byte && pcb_reg[7:6] == 2'b10 |->
    c2t_dat == 8'h00)
    else $error("receive-ready with data");
  i_present_a: assert property (len_byte && !pcb_reg[7] |->
    c2t_dat != 8'h00 && c2t_dat <= 8'hfe)
    else $error("information length out of range");
  s_one_byte_a: assert property (len_byte && pcb_reg[7:6] == 2'b11 &&
    pcb_reg[0] |-> c2t_dat == 8'h01)
    else $error("size supervisory length not one");
  s_empty_a: assert property (len_byte && pcb_reg[7:6] == 2'b11 &&
    !pcb_reg[0] |-> c2t_dat == 8'h00)
    else $error("empty supervisory with data");
endmodule : tbfl_link_assertions

/* tb/test_t1_block_frame_link.sv */
// self-checking bench: terminal and card ends joined over the link
`timescale 1ns/10ps
module test_t1_block_frame_link;
  logic        ref_clk, nrst, send, busy, ans_vld, ans_ok, rx_vld;
  logic [7:0]  pcb, len, inf, rsp_dat, rsp_len, ans_pcb, rx_dat;
  logic [7:0]  terminal_receive_size_limit;
  logic [1:0]  fault;
  logic [7:0]  last_rx;
  logic [15:0] rx_cnt;
  logic [7:0]  m_x[2], m_nad[2], m_len[2], m_inf[2];
  logic [15:0] m_n[2];
  int          n_mismatch, num_checks;
  tbfl_link_if tbfl_link_if_inst ();
  tbfl_term tbfl_term_inst (.REF_CLK_I(ref_clk), .NRST_I(nrst),
    .LINK(tbfl_link_if_inst), .SEND_I(send), .PCB_I(pcb), .LEN_I(len),
    .INF_I(inf), .FAULT_I(fault), .BUSY_O(busy), .ANS_VLD_O(ans_vld),
    .ANS_PCB_O(ans_pcb), .ANS_OK_O(ans_ok));
  tbfl_card tbfl_card_inst (.LINK(tbfl_link_if_inst), .RX_VLD_O(rx_vld),
    .RX_DAT_O(rx_dat), .RSP_DAT_I(rsp_dat), .RSP_LEN_I(rsp_len),
    .TERMINAL_RECEIVE_SIZE_LIMIT_O(terminal_receive_size_limit),
    .NRST_I(nrst));
  tbfl_link_assertions tbfl_link_assertions_inst (
    .link_clk(tbfl_link_if_inst.link_clk),
    .t2c_vld(tbfl_link_if_inst.t2c_vld), .t2c_eob(tbfl_link_if_inst.t2c_eob),
    .c2t_vld(tbfl_link_if_inst.c2t_vld), .c2t_dat(tbfl_link_if_inst.c2t_dat),
    .c2t_eob(tbfl_link_if_inst.c2t_eob), .NRST_I(nrst));
  // reference clock, 100 MHz
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // wire monitor for both directions: 0 terminal, 1 card
  task mon(input int k, input logic [7:0] d, input logic e);
    if (m_n[k] == 16'h0000) m_nad[k] = d;
    if (m_n[k] == 16'h0002) m_len[k] = d;
    if (m_n[k] == 16'h0003) m_inf[k] = d;
    m_x[k] ^= d;
    m_n[k]++;
    if (e === 1'b1) begin
      // blocks spoilt on purpose are judged by the card's answer only
      if (k == 1 || fault == 2'h0) begin
        check(m_nad[k], 8'h00);
        check(m_x[k], 8'h00);
        check(m_n[k], {8'h00, m_len[k]} + 16'h0004);
      end
      m_x[k] = 8'h00;
      m_n[k] = 16'h0000;
    end
  endtask : mon
  // strobes are one link cycle each, so the edge sees them once
  always @(posedge tbfl_link_if_inst.link_clk) begin
    if (tbfl_link_if_inst.t2c_vld === 1'b1)
      mon(0, tbfl_link_if_inst.t2c_dat, tbfl_link_if_inst.t2c_eob);
    if (tbfl_link_if_inst.c2t_vld === 1'b1)
      mon(1, tbfl_link_if_inst.c2t_dat, tbfl_link_if_inst.c2t_eob);
    if (rx_vld === 1'b1) begin
      rx_cnt++;
      last_rx = rx_dat;
    end
  end
  // one block out, bounded wait for the answer report
  task xfer(input logic [7:0] p, input logic [7:0] l, input logic [7:0] d,
            input logic [1:0] f = 2'h0);
    int i;
    @(negedge ref_clk);
    pcb = p;
    len = l;
    inf = d;
    fault = f;
    send = 1'b1;
    @(negedge ref_clk);
    send = 1'b0;
    check(busy, 1'b1);
    for (i = 0; i < 4000 && ans_vld !== 1'b1; i++) @(negedge ref_clk);
    check(busy, 1'b0);
    check(ans_ok, 1'b1);
    if (i == 4000) begin
      n_mismatch++;
      results();
    end
  endtask : xfer
  task t_ifs;
    xfer(8'hc1, 8'h01, 8'hfe);
    check(ans_pcb, 8'he1);
    check(m_inf[1], 8'hfe);
    check(terminal_receive_size_limit, 8'hfe);
    check(ans_ok, 1'b1);
    $display("test ifs done");
  endtask : t_ifs
  task t_single;
    rx_cnt = 16'h0000;
    xfer(8'h00, 8'h03, 8'h5a);
    check(ans_pcb, 8'h00);
    check(rx_cnt, 16'h0003);
    check(last_rx, 8'h5a);
    check(m_len[1], 8'h02);
    check(m_inf[1], 8'h3c);
    check(terminal_receive_size_limit, 8'hfe);
    $display("test single done");
  endtask : t_single
  task t_chain_bad;
    xfer(8'h60, 8'h02, 8'h11);
    check(ans_pcb, 8'h80);
    check(m_len[1], 8'h00);
    xfer(8'h80, 8'h01, 8'h00);
    check(ans_pcb, 8'h81);
    check(m_len[1], 8'h00);
    xfer(8'h00, 8'h01, 8'h22, 2'h1);
    check(ans_pcb, 8'h81);
    check(m_len[1], 8'h00);
    xfer(8'h00, 8'h03, 8'h22, 2'h2);
    check(ans_pcb, 8'h81);
    rx_cnt = 16'h0000;
    xfer(8'h00, 8'h01, 8'h22);
    check(ans_pcb, 8'h40);
    check(rx_cnt, 16'h0001);
    check(last_rx, 8'h22);
    xfer(8'h80, 8'h00, 8'h00);
    check(ans_pcb, 8'h90);
    $display("test chain and error done");
  endtask : t_chain_bad
  task t_super;
    xfer(8'hc2, 8'h00, 8'h00);
    check(ans_pcb, 8'he2);
    check(m_len[1], 8'h00);
    xfer(8'hc0, 8'h00, 8'h00);
    check(ans_pcb, 8'he0);
    check(m_len[1], 8'h00);
    xfer(8'h80, 8'h00, 8'h00);
    check(ans_pcb, 8'h80);
    xfer(8'h00, 8'h01, 8'h33);
    check(ans_pcb, 8'h00);
    $display("test supervisory done");
  endtask : t_super
  task t_reset;
    @(negedge ref_clk);
    nrst = 1'b0;
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    check(terminal_receive_size_limit, 8'h20);
    rsp_len = 8'h30;
    xfer(8'h00, 8'h01, 8'h01);
    check(ans_pcb, 8'h00);
    check(m_len[1], 8'h20);
    $display("test reset done");
  endtask : t_reset
  // main sequence
  initial begin
    nrst = 1'b0;
    send = 1'b0;
    fault = 2'h0;
    pcb = 8'h00;
    len = 8'h00;
    inf = 8'h00;
    rsp_dat = 8'h3c;
    rsp_len = 8'h02;
    rx_cnt = 16'h0000;
    for (int k = 0; k < 2; k++) begin
      m_x[k] = 8'h00;
      m_n[k] = 16'h0000;
    end
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    t_ifs();
    t_single();
    t_chain_bad();
    t_super();
    t_reset();
    results();
  end
endmodule : test_t1_block_frame_link
